// ==== bench/sbtio_far_model.sv ====
// far side model: arbiter, i/o target and wire levels
`timescale 1ns/10ps
`default_nettype none
module sbtio_far_model (
  input wire logic link_clk, // bus clock
  input wire logic presetn, // reset, active low
  input wire sbtio_pkg::sbtio_bus_out_t bus_o, // device drive
  input wire logic [1:0] mode, // 0 fast 1 slow 2 silent 3 abort
  input wire logic bad_par, // corrupt parity
  input wire logic grant_on, // grant while asked
  output sbtio_pkg::sbtio_bus_in_t bus_i, // wire levels
  output logic [4:0] xfers, // transfers of this transaction
  output logic last_ok // final transfer had frame high
);
  // ********************
  // wires: pull-ups, else a moving pattern when undriven
  // ********************
  logic fr, ir, pfr, cl, trdy_n, devsel_n, stop_n, gnt_n, par, rd_oe;
  logic [5:0] drv;
  logic [31:0] addr, ad, pat;
  logic [3:0] cbe;
  assign fr = bus_o.frame_oe ? bus_o.frame_n : 1'b1;
  assign ir = bus_o.irdy_oe ? bus_o.irdy_n : 1'b1;
  assign cbe = bus_o.cbe_oe ? bus_o.cbe : pat[3:0];
  assign ad = bus_o.ad_oe ? bus_o.ad : drv[0] ? 32'h5A5A0000 ^ addr : pat;
  assign bus_i = {fr, ir, drv[5:1], cbe, ad};
  // target outputs show half a clock after the edge that decides them,
  // so they stand across the next sampling edge like real bus drive
  always @(negedge link_clk or negedge presetn) begin
    if (!presetn) begin
      drv <= 6'h3C;
    end else begin
      drv <= {trdy_n, devsel_n, stop_n, gnt_n, par, rd_oe};
    end
  end
  // ********************
  // target and arbiter
  // ********************
  always @(posedge link_clk or negedge presetn) begin
    if (!presetn) begin
      {pfr, trdy_n, devsel_n, stop_n, gnt_n} <= '1;
      {cl, par, rd_oe, last_ok} <= '0;
      addr <= '0;
      xfers <= '0;
      pat <= '0;
    end else begin
      pat <= pat + 32'h9E3779B9;
      pfr <= fr;
      gnt_n <= !(grant_on && !bus_o.req_n);
      // even parity, one clock behind
      par <= ^{ad, cbe} ^ bad_par;
      if (!cl && !fr && pfr) begin
        addr <= ad;
        xfers <= '0;
        last_ok <= 1'b0;
        cl <= (mode != 2'd2);
        devsel_n <= (mode == 2'd2);
        trdy_n <= (mode >= 2'd2);
        rd_oe <= (mode != 2'd2) && (cbe == sbtio_pkg::CMD_IO_RD);
      end else if (cl && mode == 2'd3) begin
        devsel_n <= 1'b1;
        stop_n <= fr && ir && !stop_n;
        cl <= !(fr && ir && !stop_n);
      end else if (cl && !ir && !trdy_n) begin
        xfers <= xfers + 5'd1;
        trdy_n <= mode[0] || fr;
        last_ok <= fr;
        cl <= !fr;
        devsel_n <= fr;
        rd_oe <= rd_oe && !fr;
      end else if (cl) begin
        trdy_n <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_secondary_bus_tenure_io_window.sv ====
// testbench: registers, i/o window, tenure limit and status flags
`timescale 1ns/10ps
`default_nettype none
module test_secondary_bus_tenure_io_window;
  // ********************
  // signals, clocks and instances
  // ********************
  localparam logic [9:0] TM = sbtio_pkg::ADDR_TIMER;
  localparam logic [9:0] BA = sbtio_pkg::ADDR_BASE;
  localparam logic [9:0] LI = sbtio_pkg::ADDR_LIMIT;
  localparam logic [9:0] ST = sbtio_pkg::ADDR_STATUS;
  localparam logic [9:0] CT = sbtio_pkg::ADDR_CTRL;
  logic pclk, presetn, psel, penable, pwrite, link_clk, req_valid;
  logic pready, pslverr, req_ready, done, serr_req;
  logic bad_par, grant_on, drop_arm, last_ok;
  logic [1:0] mode;
  logic [4:0] xfers;
  logic [9:0] paddr;
  logic [31:0] pwdata, prdata, fl;
  sbtio_pkg::sbtio_bus_in_t bus_i;
  sbtio_pkg::sbtio_bus_out_t bus_o;
  sbtio_pkg::sbtio_req_t req;
  sbtio_pkg::sbtio_done_t done_info;
  int error_cnt, compares, serr_cnt, s0;
  logic [31:0] wa [5] = '{32'h1FFC, 32'h2000, 32'h3FFC, 32'h4000, 32'h12000};
  logic [1:0] wc [5] = '{2'h1, 2'h0, 2'h0, 2'h1, 2'h1};

  sbtio_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .link_clk, .bus_i, .bus_o,
    .req_valid, .req, .req_ready, .done, .done_info, .serr_req);
  sbtio_far_model u_far (.link_clk, .presetn, .bus_o, .mode, .bad_par,
    .grant_on, .bus_i, .xfers, .last_ok);

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    link_clk = 1'b0;
    #3;
    forever #62.5 link_clk = ~link_clk;
  end
  // count error reports; withdraw grant once a burst has begun
  always @(posedge pclk) begin
    if (serr_req === 1'b1) serr_cnt <= serr_cnt + 1;
    if (drop_arm && bus_i.frame_n === 1'b0) grant_on <= 1'b0;
  end
  // ********************
  // checks, bus tasks and verdict
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a,
                     input logic [31:0] d, input logic [31:0] exp,
                     input logic eerr);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    chk({31'h0, pready}, 32'h1);
    if (!w) chk(prdata, exp);
    chk({31'h0, pslverr}, {31'h0, eerr});
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic io(input logic [31:0] a, input logic w,
                    input logic [4:0] n, input logic [1:0] code);
    int k;
    k = 0;
    while (req_ready !== 1'b1 && k < 5000) begin
      @(posedge pclk);
      k++;
    end
    req_valid <= 1'b1;
    req <= '{addr: a, write: w, len: n, wdata: 32'h1234ABCD};
    @(posedge pclk);
    req_valid <= 1'b0;
    while (done !== 1'b1 && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    chk({31'h0, done}, 32'h1);
    chk({30'h0, done_info.code}, {30'h0, code});
    if (code == sbtio_pkg::DONE_OK) begin
      chk({27'h0, done_info.count}, {27'h0, xfers});
      chk({31'h0, last_ok}, 32'h1);
    end
  endtask
  task test_done;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #900000;
    error_cnt++;
    test_done();
  end
  // ********************
  // test sequence
  // ********************
  initial begin
    {presetn, psel, penable, pwrite, req_valid, bad_par, drop_arm} = '0;
    {paddr, pwdata, req, mode} = '0;
    grant_on = 1'b1;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, TM, 32'h0, 32'h00, 1'b0);
    apb(1'b0, BA, 32'h0, 32'hF0, 1'b0);
    apb(1'b0, LI, 32'h0, 32'h00, 1'b0);
    apb(1'b0, ST, 32'h0, 32'h02A0, 1'b0);
    apb(1'b0, CT, 32'h0, 32'h00, 1'b0);
    apb(1'b0, 10'h080, 32'h0, 32'h0, 1'b1);
    apb(1'b1, TM, 32'hFF, 32'h0, 1'b0);
    apb(1'b0, TM, 32'h0, 32'hF8, 1'b0);
    apb(1'b1, BA, 32'hFF, 32'h0, 1'b0);
    apb(1'b0, BA, 32'h0, 32'hF0, 1'b0);
    apb(1'b1, ST, 32'hFFFF, 32'h0, 1'b0);
    apb(1'b0, ST, 32'h0, 32'h02A0, 1'b0);
    apb(1'b1, BA, 32'h20, 32'h0, 1'b0);
    apb(1'b1, LI, 32'h3F, 32'h0, 1'b0);
    apb(1'b0, LI, 32'h0, 32'h30, 1'b0);
    for (int i = 0; i < 5; i++) begin
      io(wa[i], 1'b0, 5'd1, wc[i]);
      if (wc[i] == 2'h0) chk(done_info.rdata, 32'h5A5A0000 ^ wa[i]);
    end
    for (int m = 0; m < 2; m++) begin
      mode <= 2'(m);
      io(32'h2100, 1'b1, 5'd4, sbtio_pkg::DONE_OK);
    end
    for (int m = 2; m < 4; m++) begin
      mode <= 2'(m);
      fl = (m == 2) ? 32'h2000 : 32'h1000;
      io(32'h2200, 1'b1, 5'd1, 2'(m));
      apb(1'b0, ST, 32'h0, 32'h02A0 | fl, 1'b0);
      apb(1'b1, ST, 32'h0, 32'h0, 1'b0);
      apb(1'b0, ST, 32'h0, 32'h02A0 | fl, 1'b0);
      apb(1'b1, ST, fl, 32'h0, 1'b0);
      apb(1'b0, ST, 32'h0, 32'h02A0, 1'b0);
    end
    mode <= 2'd0;
    for (int c = 1; c < 4; c += 2) begin
      apb(1'b1, CT, 32'(c), 32'h0, 1'b0);
      apb(1'b0, CT, 32'h0, 32'(c), 1'b0);
      s0 = serr_cnt;
      bad_par <= 1'b1;
      io(32'h2300, 1'b1, 5'd2, sbtio_pkg::DONE_OK);
      // parity is judged one link clock after the last transfer
      repeat (40) @(posedge pclk);
      bad_par <= 1'b0;
      chk(32'(serr_cnt > s0), 32'(c == 3));
      apb(1'b0, ST, 32'h0, 32'h82A0, 1'b0);
      apb(1'b1, ST, 32'h8000, 32'h0, 1'b0);
      apb(1'b0, ST, 32'h0, 32'h02A0, 1'b0);
    end
    mode <= 2'd1;
    for (int t = 0; t < 3; t++) begin
      apb(1'b1, TM, (t == 0) ? 32'h00 : 32'h0F, 32'h0, 1'b0);
      drop_arm <= (t != 1);
      io(32'h2400, 1'b1, 5'd31, sbtio_pkg::DONE_OK);
      drop_arm <= 1'b0;
      grant_on <= 1'b1;
      if (t == 2) chk(32'(xfers < 5'd11), 32'h1);
      else chk({27'h0, xfers}, 32'd31);
    end
    test_done();
  end
endmodule
`default_nettype wire

// ==== hw/sbtio_pkg.sv ====
// package: constants, carrier types and shared functions of the tenure block
// ****************************************************************
// Notes on behaviour
// - timer bits 7:3 form count, low three zero
// - load counter when first frame is asserted
// - expired and grant gone: give up bus
// - grant held: keep bus despite expiry
// - frame deasserted before the final transfer
// - count bus clocks, finish phase, then release
// - timer zero disables the tenure limit
// - base nibble gives A15:12, low bits zero
// - base low nibble reads zero, 16-bit only
// - limit nibble gives A15:12, low bits ones
// - forward I/O access inside base..limit window
// - parity error sets bit 15, write-one clears
// - master abort sets bit 13, write-one clears
// - target abort sets bit 12, write-one clears
// - hardwired status bits, reset value 02A0h
// - never signal target abort, accept back-to-back
// - data parity reported when both enables set
// - control bit 0 enables parity response
// ****************************************************************
`default_nettype none
package sbtio_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_TIMER = 8'h1B;
  localparam logic [7:0] IDX_BASE = 8'h1C;
  localparam logic [7:0] IDX_LIMIT = 8'h1D;
  localparam logic [7:0] IDX_STATUS = 8'h1E;
  localparam logic [7:0] IDX_CTRL = 8'h3E;
  localparam logic [9:0] ADDR_TIMER = {IDX_TIMER, 2'b00};
  localparam logic [9:0] ADDR_BASE = {IDX_BASE, 2'b00};
  localparam logic [9:0] ADDR_LIMIT = {IDX_LIMIT, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_CTRL = {IDX_CTRL, 2'b00};

  // reset values
  localparam logic [7:0] TIMER_RST = 8'h00;
  localparam logic [7:0] BASE_RST = 8'hF0;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [15:0] STATUS_RST = 16'h02A0;
  localparam logic [7:0] CTRL_RST = 8'h00;

  // field positions
  localparam int TIMER_LSB = 3;
  localparam int WIN_LSB = 4;
  localparam int ST_DPE = 15;
  localparam int ST_RMA = 13;
  localparam int ST_RTA = 12;
  localparam int CTRL_PRE = 0;
  localparam int CTRL_SEE = 1;

  // decode fill and bus encodings
  localparam logic [15:0] IO_UPPER = 16'h0000;
  localparam logic [11:0] IO_BASE_FILL = 12'h000;
  localparam logic [11:0] IO_LIMIT_FILL = 12'hFFF;
  localparam logic [3:0] CMD_IO_RD = 4'h2;
  localparam logic [3:0] CMD_IO_WR = 4'h3;
  localparam logic [3:0] BE_ALL = 4'h0;
  localparam logic [2:0] DEVSEL_WAIT = 3'h5;

  localparam logic [1:0] DONE_OK = 2'h0;
  localparam logic [1:0] DONE_MISS = 2'h1;
  localparam logic [1:0] DONE_MABORT = 2'h2;
  localparam logic [1:0] DONE_TABORT = 2'h3;

  typedef enum logic [2:0] {
    S_IDLE, S_REQ, S_ADDR, S_DATA, S_LAST, S_TURN
  } sbtio_state_t;

  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic trdy_n;
    logic devsel_n;
    logic stop_n;
    logic gnt_n;
    logic par;
    logic [3:0] cbe;
    logic [31:0] ad;
  } sbtio_bus_in_t;

  typedef struct packed {
    logic req_n;
    logic frame_n;
    logic frame_oe;
    logic irdy_n;
    logic irdy_oe;
    logic [3:0] cbe;
    logic cbe_oe;
    logic [31:0] ad;
    logic ad_oe;
  } sbtio_bus_out_t;

  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic [4:0] len;
    logic [31:0] wdata;
  } sbtio_req_t;

  typedef struct packed {
    logic [1:0] code;
    logic [4:0] count;
    logic [31:0] rdata;
  } sbtio_done_t;

  function automatic logic sbtio_io_hit(input logic [31:0] a,
                                        input logic [3:0] b,
                                        input logic [3:0] l);
    sbtio_io_hit = (a[31:16] == IO_UPPER) &&
                   (a[15:0] >= {b, IO_BASE_FILL}) &&
                   (a[15:0] <= {l, IO_LIMIT_FILL});
  endfunction

  function automatic logic [15:0] sbtio_status(input logic dpe,
                                               input logic rma,
                                               input logic rta);
    sbtio_status = STATUS_RST;
    sbtio_status[ST_DPE] = dpe;
    sbtio_status[ST_RMA] = rma;
    sbtio_status[ST_RTA] = rta;
  endfunction

endpackage
`default_nettype wire

// ==== hw/sbtio_top.sv ====
// module: secondary bus tenure timer, I/O window and status over APB
//
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module sbtio_top #(
  parameter int ADDR_W = 10
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // asynchronous reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic link_clk, // secondary bus clock
  input wire sbtio_pkg::sbtio_bus_in_t bus_i, // secondary bus pins in
  output sbtio_pkg::sbtio_bus_out_t bus_o, // secondary bus pins out
  input wire logic req_valid, // host hub i/o request
  input wire sbtio_pkg::sbtio_req_t req, // request fields
  output logic req_ready, // request taken
  output logic done, // request finished
  output sbtio_pkg::sbtio_done_t done_info, // finish code and data
  output logic serr_req // system error special cycle request
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic lk_s1;
    logic lk_s2;
    logic lk_s3;
    sbtio_pkg::sbtio_bus_in_t in_s1;
    sbtio_pkg::sbtio_bus_in_t in_s2;
    logic [4:0] timer;
    logic [3:0] base;
    logic [3:0] limit;
    logic ctrl_pre;
    logic ctrl_see;
    logic dpe;
    logic rma;
    logic rta;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    sbtio_pkg::sbtio_state_t fsm;
    logic [7:0] lat;
    logic [4:0] left;
    logic [2:0] dsel_cnt;
    logic got_dsel;
    logic abort;
    logic prev_frame_n;
    logic chk_par;
    logic chk_data;
    logic par_ref;
    sbtio_pkg::sbtio_req_t job;
    sbtio_pkg::sbtio_bus_out_t bo;
    logic req_ready;
    logic done;
    sbtio_pkg::sbtio_done_t info;
    logic serr_req;
  } sbtio_st_t;

  sbtio_st_t st;
  sbtio_st_t next_st;

  initial begin
    if (ADDR_W < 10) begin
      $error("ADDR_W must be at least 10");
    end
  end

  logic lk;
  logic gnt;
  logic expired;
  logic preempt;
  logic setup;
  logic wr;
  logic hit;
  logic par_bad;
  logic xfer;
  logic stop;
  logic dsel;
  logic dsel_to;
  logic tabort;
  logic up_bad;
  logic [9:0] a10;

  assign a10 = paddr[9:0];
  assign up_bad = (paddr >> 10) != '0;
  assign lk = st.lk_s2 & ~st.lk_s3;
  assign gnt = ~st.in_s2.gnt_n;
  assign expired = (st.timer != 5'h00) && (st.lat == 8'h00);
  assign preempt = expired && !gnt;
  assign setup = psel && !penable;
  assign wr = psel && penable && st.pready && pwrite;
  assign hit = sbtio_pkg::sbtio_io_hit(req.addr, st.base, st.limit);
  assign par_bad = lk && st.chk_par && (st.par_ref != st.in_s2.par);
  assign xfer = ~st.in_s2.trdy_n;
  assign stop = ~st.in_s2.stop_n;
  assign dsel = ~st.in_s2.devsel_n;
  assign dsel_to = !st.got_dsel && !dsel &&
                   (st.dsel_cnt == sbtio_pkg::DEVSEL_WAIT);
  assign tabort = stop && !dsel && st.got_dsel;

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    next_st = st;
    next_st.lk_s1 = link_clk;
    next_st.lk_s2 = st.lk_s1;
    next_st.lk_s3 = st.lk_s2;
    next_st.in_s1 = bus_i;
    next_st.in_s2 = st.in_s1;
    next_st.done = 1'b0;
    next_st.serr_req = 1'b0;

    // apb: decode in setup, answer in the first access cycle
    next_st.pready = setup;
    next_st.pslverr = 1'b0;
    if (setup) begin
      next_st.prdata = 32'h0000_0000;
      if (up_bad) begin
        next_st.pslverr = 1'b1;
      end else begin
        case (a10)
          sbtio_pkg::ADDR_TIMER: next_st.prdata[7:0] = {st.timer, 3'h0};
          sbtio_pkg::ADDR_BASE: next_st.prdata[7:0] = {st.base, 4'h0};
          sbtio_pkg::ADDR_LIMIT: next_st.prdata[7:0] = {st.limit, 4'h0};
          sbtio_pkg::ADDR_STATUS: next_st.prdata[15:0] =
            sbtio_pkg::sbtio_status(st.dpe, st.rma, st.rta);
          sbtio_pkg::ADDR_CTRL: next_st.prdata[1:0] = {st.ctrl_see, st.ctrl_pre};
          default: next_st.pslverr = 1'b1;
        endcase
      end
    end
    if (wr && !up_bad) begin
      case (a10)
        sbtio_pkg::ADDR_TIMER: next_st.timer = pwdata[7:sbtio_pkg::TIMER_LSB];
        sbtio_pkg::ADDR_BASE: next_st.base = pwdata[7:sbtio_pkg::WIN_LSB];
        sbtio_pkg::ADDR_LIMIT: next_st.limit = pwdata[7:sbtio_pkg::WIN_LSB];
        sbtio_pkg::ADDR_STATUS: begin
          // clear first so an event in this cycle still sets below
          if (pwdata[sbtio_pkg::ST_DPE]) next_st.dpe = 1'b0;
          if (pwdata[sbtio_pkg::ST_RMA]) next_st.rma = 1'b0;
          if (pwdata[sbtio_pkg::ST_RTA]) next_st.rta = 1'b0;
        end
        sbtio_pkg::ADDR_CTRL: begin
          next_st.ctrl_pre = pwdata[sbtio_pkg::CTRL_PRE];
          next_st.ctrl_see = pwdata[sbtio_pkg::CTRL_SEE];
        end
        default: next_st.ctrl_pre = st.ctrl_pre;
      endcase
    end

    // parity watch on every bus clock, master or target
    if (lk) begin
      next_st.par_ref = ^{st.in_s2.ad, st.in_s2.cbe};
      next_st.chk_data = !st.in_s2.irdy_n && !st.in_s2.trdy_n;
      next_st.chk_par = (!st.in_s2.frame_n && st.prev_frame_n) ||
                        (!st.in_s2.irdy_n && !st.in_s2.trdy_n);
      next_st.prev_frame_n = st.in_s2.frame_n;
    end
    if (par_bad) begin
      next_st.dpe = 1'b1;
      if (st.chk_data && st.ctrl_pre && st.ctrl_see) begin
        next_st.serr_req = 1'b1;
      end
    end

    // tenure counter runs in bus clocks while we own the bus
    if (lk && st.lat != 8'h00 &&
        (st.fsm == sbtio_pkg::S_ADDR || st.fsm == sbtio_pkg::S_DATA ||
         st.fsm == sbtio_pkg::S_LAST)) begin
      next_st.lat = st.lat - 8'h01;
    end
    if (lk && !st.got_dsel &&
        (st.fsm == sbtio_pkg::S_DATA || st.fsm == sbtio_pkg::S_LAST)) begin
      next_st.got_dsel = dsel;
      next_st.dsel_cnt = st.dsel_cnt + 3'h1;
    end

    // ****************************************************************
    // master sequencer
    // ****************************************************************
    case (st.fsm)
      sbtio_pkg::S_IDLE: begin
        next_st.req_ready = 1'b1;
        if (req_valid && st.req_ready) begin
          next_st.req_ready = 1'b0;
          next_st.job = req;
          next_st.left = (req.len == 5'h00) ? 5'h01 : req.len;
          next_st.info = '0;
          if (hit) begin
            next_st.bo.req_n = 1'b0;
            next_st.fsm = sbtio_pkg::S_REQ;
          end else begin
            next_st.info.code = sbtio_pkg::DONE_MISS;
            next_st.done = 1'b1;
            next_st.fsm = sbtio_pkg::S_TURN;
          end
        end
      end
      sbtio_pkg::S_REQ: begin
        if (lk && gnt && st.in_s2.frame_n && st.in_s2.irdy_n) begin
          next_st.bo.frame_n = 1'b0;
          next_st.bo.frame_oe = 1'b1;
          next_st.bo.irdy_n = 1'b1;
          next_st.bo.irdy_oe = 1'b1;
          next_st.bo.ad = st.job.addr;
          next_st.bo.ad_oe = 1'b1;
          next_st.bo.cbe = st.job.write ? sbtio_pkg::CMD_IO_WR
                                         : sbtio_pkg::CMD_IO_RD;
          next_st.bo.cbe_oe = 1'b1;
          next_st.lat = {st.timer, 3'h0};
          next_st.got_dsel = 1'b0;
          next_st.dsel_cnt = 3'h0;
          next_st.abort = 1'b0;
          next_st.fsm = sbtio_pkg::S_ADDR;
        end
      end
      sbtio_pkg::S_ADDR: begin
        if (lk) begin
          next_st.bo.irdy_n = 1'b0;
          next_st.bo.cbe = sbtio_pkg::BE_ALL;
          next_st.bo.ad = st.job.wdata;
          next_st.bo.ad_oe = st.job.write;
          if (st.left == 5'h01) begin
            next_st.bo.frame_n = 1'b1;
            next_st.bo.req_n = 1'b1;
            next_st.fsm = sbtio_pkg::S_LAST;
          end else begin
            next_st.fsm = sbtio_pkg::S_DATA;
          end
        end
      end
      sbtio_pkg::S_DATA: begin
        if (lk) begin
          if (dsel_to || tabort) begin
            if (dsel_to) begin
              next_st.rma = 1'b1;
              next_st.info.code = sbtio_pkg::DONE_MABORT;
            end else begin
              next_st.rta = 1'b1;
              next_st.info.code = sbtio_pkg::DONE_TABORT;
            end
            next_st.abort = 1'b1;
            next_st.bo.frame_n = 1'b1;
            next_st.bo.req_n = 1'b1;
            next_st.fsm = sbtio_pkg::S_LAST;
          end else begin
            if (xfer) begin
              next_st.left = st.left - 5'h01;
              next_st.info.count = st.info.count + 5'h01;
              next_st.info.rdata = st.in_s2.ad;
            end
            // a held grant keeps the bus whatever the counter says
            if ((xfer && st.left == 5'h02) || stop || preempt) begin
              next_st.bo.frame_n = 1'b1;
              next_st.bo.req_n = 1'b1;
              next_st.fsm = sbtio_pkg::S_LAST;
            end
          end
        end
      end
      sbtio_pkg::S_LAST: begin
        if (lk) begin
          if (dsel_to) begin
            next_st.rma = 1'b1;
          end else if (tabort && !st.abort) begin
            next_st.rta = 1'b1;
          end
          if (st.abort || dsel_to || xfer || stop) begin
            if (xfer && !st.abort && !dsel_to) begin
              next_st.info.count = st.info.count + 5'h01;
              next_st.info.rdata = st.in_s2.ad;
            end
            next_st.info.code = dsel_to ? sbtio_pkg::DONE_MABORT :
                                st.abort ? st.info.code :
                                tabort ? sbtio_pkg::DONE_TABORT :
                                sbtio_pkg::DONE_OK;
            next_st.bo.irdy_n = 1'b1;
            next_st.bo.ad_oe = 1'b0;
            next_st.done = 1'b1;
            next_st.fsm = sbtio_pkg::S_TURN;
          end
        end
      end
      sbtio_pkg::S_TURN: begin
        // irdy was driven high for one bus clock, frame for at least two; now float
        if (lk || st.bo.frame_oe == 1'b0) begin
          next_st.bo.frame_oe = 1'b0;
          next_st.bo.irdy_oe = 1'b0;
          next_st.bo.cbe_oe = 1'b0;
          next_st.fsm = sbtio_pkg::S_IDLE;
        end
      end
      default: next_st.fsm = sbtio_pkg::S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
      st.in_s1 <= '1;
      st.in_s2 <= '1;
      st.prev_frame_n <= 1'b1;
      st.timer <= sbtio_pkg::TIMER_RST[7:3];
      st.base <= sbtio_pkg::BASE_RST[7:4];
      st.limit <= sbtio_pkg::LIMIT_RST[7:4];
      st.ctrl_pre <= sbtio_pkg::CTRL_RST[0];
      st.ctrl_see <= sbtio_pkg::CTRL_RST[1];
      st.fsm <= sbtio_pkg::S_IDLE;
      st.bo.req_n <= 1'b1;
      st.bo.frame_n <= 1'b1;
      st.bo.irdy_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign bus_o = st.bo;
  assign req_ready = st.req_ready;
  assign done = st.done;
  assign done_info = st.info;
  assign serr_req = st.serr_req;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_read_setup(logic [9:0] adr);
    setup && !pwrite && a10 == adr && !up_bad;
  endsequence
  sequence s_last_phase;
    bus_o.frame_n && !bus_o.irdy_n && bus_o.irdy_oe;
  endsequence
  sequence s_released;
    bus_o.frame_n && bus_o.irdy_n;
  endsequence

  a_timer_low_zero: assert property (
    s_read_setup(sbtio_pkg::ADDR_TIMER) |=> pready && prdata[2:0] == 3'h0 &&
      prdata[7:3] == $past(st.timer))
    else $error("timer low bits not zero");
  a_lat_load: assert property (
    st.fsm == sbtio_pkg::S_REQ ##1 st.fsm == sbtio_pkg::S_ADDR |->
      !bus_o.frame_n && st.lat == {st.timer, 3'h0})
    else $error("latency count not loaded at frame");
  a_grant_keeps: assert property (
    lk && st.fsm == sbtio_pkg::S_DATA && gnt && !stop && !xfer &&
      st.got_dsel |=> st.fsm == sbtio_pkg::S_DATA && !bus_o.frame_n)
    else $error("bus released while granted");
  a_preempt_end: assert property (
    lk && st.fsm == sbtio_pkg::S_DATA && preempt && st.got_dsel && !stop
      |=> s_last_phase)
    else $error("no release after expiry and lost grant");
  a_frame_first: assert property (
    $rose(bus_o.irdy_n) && bus_o.irdy_oe |-> $past(bus_o.frame_n))
    else $error("irdy released before frame");
  a_no_limit: assert property (
    lk && st.fsm == sbtio_pkg::S_DATA && st.timer == 5'h00 && !stop && !xfer
      && st.got_dsel |=> st.fsm == sbtio_pkg::S_DATA)
    else $error("zero timer ended burst");
  a_window_miss: assert property (
    st.fsm == sbtio_pkg::S_IDLE && req_valid && req_ready && !hit |=>
      done && done_info.code == sbtio_pkg::DONE_MISS ##1 s_released)
    else $error("out of window access forwarded");
  a_parity_flag: assert property (
    par_bad |=> st.dpe)
    else $error("parity error not flagged");
  a_w1c_zero: assert property (
    wr && a10 == sbtio_pkg::ADDR_STATUS && !pwdata[sbtio_pkg::ST_RMA] &&
      st.rma |=> st.rma)
    else $error("zero write cleared flag");
  a_serr_gate: assert property (
    serr_req |-> $past(st.ctrl_pre) && $past(st.ctrl_see))
    else $error("system error report not gated");
  a_status_fixed: assert property (
    s_read_setup(sbtio_pkg::ADDR_STATUS) |=> prdata[14] == 1'b0 &&
      prdata[11] == 1'b0 && prdata[10:9] == 2'h1 && prdata[8] == 1'b0 &&
      prdata[7] && prdata[5])
    else $error("hardwired status bits wrong");

endmodule
`default_nettype wire
